// [core/hsc_detect.sv]
// Stop and idle detection on the backplane lines
`timescale 1ns/1ps
`include "hsc_regs.svh"
module hsc_detect #(
  parameter int IDLE_CYCLES = `HSC_IDLE_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic arm,
  hsc_lines_if.det  lines
);
  logic                       data_q_r;
  logic [`HSC_IDLE_CNT_W-1:0] idle_cnt_r;
  logic                       stop_r;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      data_q_r <= 1'b1;
      stop_r   <= 1'b0;
    end else begin
      data_q_r <= lines.bp_data;
      stop_r   <= arm && lines.bp_clk && lines.bp_data && !data_q_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n || !arm || !lines.bp_data || !lines.bp_clk) begin
      idle_cnt_r <= '0;
    end else if (idle_cnt_r != IDLE_CYCLES[`HSC_IDLE_CNT_W-1:0]) begin
      idle_cnt_r <= idle_cnt_r + 1'b1;
    end
  end

  assign lines.stop_seen = stop_r;
  assign lines.idle_seen = (idle_cnt_r == IDLE_CYCLES[`HSC_IDLE_CNT_W-1:0]);
endmodule

// [core/hsc_lines_if.sv]
// Synchronised line levels shared between controller modules
`timescale 1ns/1ps
interface hsc_lines_if;
  logic bp_data;
  logic bp_clk;
  logic card_data;
  logic card_clk;
  logic stop_seen;
  logic idle_seen;
  modport src (output bp_data, bp_clk, card_data, card_clk);
  modport det (input bp_data, bp_clk, output stop_seen, idle_seen);
  modport use_side (input bp_data, bp_clk, card_data, card_clk,
                    stop_seen, idle_seen);
endinterface

// [core/hsc_pkg.sv]
// Types for the hot-swap connect controller
package hsc_pkg;
  typedef enum logic [3:0] {
    HSC_LOCKOUT = 4'h1,
    HSC_QUALIFY = 4'h2,
    HSC_JOINED  = 4'h4,
    HSC_OFF     = 4'h8
  } hsc_state_t;
endpackage

// [core/hsc_regs.svh]
// Constants for the hot-swap two-wire connect controller
// Operation
// - Connected flag low while enable low or start-up not finished
// - Connected flag high only when enabled, qualified and sides joined
// - Enable low separates sides, stops boost, clears flag, stops pre-charge
// - After enable returns, rejoin only after same qualification as start-up
// - Stay in supply lockout, ignoring lines, until supply is good
// - Keep pre-charge active during supply lockout
// - After lockout, watch backplane for stop or idle
// - Then require card data and clock high before joining and boosting
// - While joined, a low on either line of a pair pulls both low
// - While joined, a pair rises only when all parties release it
// - Boost pull-up on all four lines only after connection
// - Start with no connection between backplane and card lines
// - Backplane idle after no activity for about 95 us (50 to 150)
`ifndef HSC_REGS_SVH
`define HSC_REGS_SVH
`define HSC_CLK_MHZ        25
`define HSC_IDLE_TIME_US   95
`define HSC_IDLE_CYCLES    (`HSC_IDLE_TIME_US * `HSC_CLK_MHZ)
`define HSC_IDLE_CNT_W     12
`endif

// [core/hsc_sync.sv]
// Two-stage synchroniser for the four bus lines
`timescale 1ns/1ps
module hsc_sync (
  input  wire logic  sys_clk,
  input  wire logic  reset_n,
  input  wire logic [3:0] lines_in,
  hsc_lines_if.src   lines
);
  logic [3:0] meta_r;
  logic [3:0] sync_r;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_bit
      always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
          meta_r[g] <= 1'b1;
          sync_r[g] <= 1'b1;
        end else begin
          meta_r[g] <= lines_in[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign lines.bp_data   = sync_r[0];
  assign lines.bp_clk    = sync_r[1];
  assign lines.card_data = sync_r[2];
  assign lines.card_clk  = sync_r[3];
endmodule

// [core/hsc_top.sv]
// Hot-swap two-wire bus connect controller
`timescale 1ns/1ps
`include "hsc_regs.svh"
module hsc_top #(
  parameter int IDLE_CYCLES = `HSC_IDLE_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic bus_enable,
  input  wire logic supply_good,
  input  wire logic backplane_data_line_in,
  output logic      backplane_data_line_out,
  output logic      backplane_data_line_oe,
  input  wire logic backplane_clock_line_in,
  output logic      backplane_clock_line_out,
  output logic      backplane_clock_line_oe,
  input  wire logic card_data_line_in,
  output logic      card_data_line_out,
  output logic      card_data_line_oe,
  input  wire logic card_clock_line_in,
  output logic      card_clock_line_out,
  output logic      card_clock_line_oe,
  output logic      connected_flag,
  output logic      boost_enable,
  output logic      precharge_enable,
  output hsc_pkg::hsc_state_t state
);
  import hsc_pkg::*;

  hsc_lines_if lines ();

  logic       en_meta_r;
  logic       en_r;
  logic       sup_meta_r;
  logic       sup_r;
  hsc_state_t state_r;
  hsc_state_t state_nxt;
  logic       joined;
  logic [3:0] oe_now;
  logic [3:0] oe_d1_r;
  logic [3:0] oe_d2_r;
  logic [3:0] self_low;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  hsc_sync u_sync (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .lines_in ({card_clock_line_in, card_data_line_in,
                backplane_clock_line_in, backplane_data_line_in}),
    .lines    (lines)
  );

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      en_meta_r  <= 1'b0;
      en_r       <= 1'b0;
      sup_meta_r <= 1'b0;
      sup_r      <= 1'b0;
    end else begin
      en_meta_r  <= bus_enable;
      en_r       <= en_meta_r;
      sup_meta_r <= supply_good;
      sup_r      <= sup_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // Stop and idle detection
  // ---------------------------------------------------------------
  hsc_detect #(
    .IDLE_CYCLES (IDLE_CYCLES)
  ) u_detect (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .arm     (state_r == HSC_QUALIFY),
    .lines   (lines)
  );

  // ---------------------------------------------------------------
  // Connection state machine
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      HSC_LOCKOUT: begin
        if (sup_r) begin
          state_nxt = en_r ? HSC_QUALIFY : HSC_OFF;
        end
      end
      HSC_QUALIFY: begin
        if (!sup_r) begin
          state_nxt = HSC_LOCKOUT;
        end else if (!en_r) begin
          state_nxt = HSC_OFF;
        end else if ((lines.stop_seen || lines.idle_seen) &&
                     lines.card_data && lines.card_clk) begin
          state_nxt = HSC_JOINED;
        end
      end
      HSC_JOINED: begin
        if (!sup_r) begin
          state_nxt = HSC_LOCKOUT;
        end else if (!en_r) begin
          state_nxt = HSC_OFF;
        end
      end
      HSC_OFF: begin
        if (!sup_r) begin
          state_nxt = HSC_LOCKOUT;
        end else if (en_r) begin
          state_nxt = HSC_QUALIFY;
        end
      end
      default: state_nxt = HSC_LOCKOUT;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_r <= HSC_LOCKOUT;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign joined = (state_r == HSC_JOINED);

  // ---------------------------------------------------------------
  // Wired-AND joining of each line pair
  // ---------------------------------------------------------------
  // Bit 3 bp data, 2 bp clock, 1 card data, 0 card clock
  assign oe_now = {backplane_data_line_oe, backplane_clock_line_oe,
                   card_data_line_oe, card_clock_line_oe};

  // Own drive history covering the synchroniser latency
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      oe_d1_r <= 4'h0;
      oe_d2_r <= 4'h0;
    end else begin
      oe_d1_r <= oe_now;
      oe_d2_r <= oe_d1_r;
    end
  end

  // Lows that may still be our own drive are not passed back,
  // so a pair cannot latch itself low
  assign self_low = oe_now | oe_d1_r | oe_d2_r;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      backplane_data_line_oe  <= 1'b0;
      card_data_line_oe       <= 1'b0;
      backplane_clock_line_oe <= 1'b0;
      card_clock_line_oe      <= 1'b0;
    end else if (!joined || state_nxt != HSC_JOINED) begin
      backplane_data_line_oe  <= 1'b0;
      card_data_line_oe       <= 1'b0;
      backplane_clock_line_oe <= 1'b0;
      card_clock_line_oe      <= 1'b0;
    end else begin
      // Drive the side that is not the source of the low
      backplane_data_line_oe  <= !lines.card_data && !self_low[1];
      card_data_line_oe       <= !lines.bp_data && !self_low[3];
      backplane_clock_line_oe <= !lines.card_clk && !self_low[0];
      card_clock_line_oe      <= !lines.bp_clk && !self_low[2];
    end
  end

  // ---------------------------------------------------------------
  // Status and analog controls
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      backplane_data_line_out  <= 1'b0;
      backplane_clock_line_out <= 1'b0;
      card_data_line_out       <= 1'b0;
      card_clock_line_out      <= 1'b0;
      connected_flag           <= 1'b0;
      boost_enable             <= 1'b0;
      precharge_enable         <= 1'b1;
      state                    <= HSC_LOCKOUT;
    end else begin
      backplane_data_line_out  <= 1'b0;
      backplane_clock_line_out <= 1'b0;
      card_data_line_out       <= 1'b0;
      card_clock_line_out      <= 1'b0;
      connected_flag           <= (state_nxt == HSC_JOINED);
      boost_enable             <= (state_nxt == HSC_JOINED);
      precharge_enable         <= (state_nxt == HSC_LOCKOUT) ||
                                  (state_nxt == HSC_QUALIFY);
      state                    <= state_nxt;
    end
  end
endmodule

// [tb/hsc_bus_model.sv]
// Open-drain lines with pull-ups and a backplane clock source
`timescale 1ns/1ps
module hsc_bus_model (
  input  wire logic       run_clk,
  input  wire logic [3:0] pull,
  input  wire logic [3:0] oe,
  output logic [3:0]      line
);
  logic link_clk;

  // Clock stands high outside frames
  initial begin
    link_clk = 1'b1;
    forever begin
      #160 link_clk = run_clk ? ~link_clk : 1'b1;
    end
  end

  // Bit 3 bp data, 2 bp clock, 1 card data, 0 card clock
  assign line = ~(pull | oe | {1'b0, ~link_clk, 2'b00});
endmodule

// [tb/hsc_top_chk.sv]
// Assertions on the connect controller ports
`timescale 1ns/1ps
module hsc_top_chk (
  input wire logic               sys_clk,
  input wire logic               reset_n,
  input wire logic               bus_enable,
  input wire logic               supply_good,
  input wire logic               backplane_clock_line_in,
  input wire logic               card_data_line_in,
  input wire logic               backplane_data_line_oe,
  input wire logic               backplane_clock_line_oe,
  input wire logic               card_data_line_oe,
  input wire logic               card_clock_line_oe,
  input wire logic               connected_flag,
  input wire logic               boost_enable,
  input wire logic               precharge_enable,
  input wire hsc_pkg::hsc_state_t state
);
  import hsc_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_FLAG_CAUSE: assert property ($rose(connected_flag) |->
    state == HSC_JOINED) else $error("flag rose unjoined");
  AST_BOOST_FLAG: assert property (boost_enable == connected_flag)
    else $error("boost differs from flag");
  AST_LOCK_PRECHARGE: assert property (state == HSC_LOCKOUT |->
    precharge_enable && !connected_flag) else $error("lockout outputs");
  AST_LOCK_HOLD: assert property (state == HSC_LOCKOUT &&
    !supply_good && !$past(supply_good) && !$past(supply_good, 2)
    |=> state == HSC_LOCKOUT) else $error("left lockout early");
  AST_EN_DROP: assert property ($fell(bus_enable) |->
    ##[1:4] !connected_flag && !boost_enable) else $error("slow drop");
  AST_OFF_QUIET: assert property (!bus_enable [*5] |->
    !connected_flag && !(backplane_data_line_oe | backplane_clock_line_oe
    | card_data_line_oe | card_clock_line_oe)) else $error("off drives");
  AST_DATA_AND: assert property ((state == HSC_JOINED &&
    !card_data_line_in && !card_data_line_oe) [*5]
    |-> backplane_data_line_oe) else $error("data low not passed");
  AST_CLK_RELEASE: assert property (backplane_clock_line_in [*5]
    |-> !card_clock_line_oe) else $error("clock low held");
endmodule

bind hsc_top hsc_top_chk u_chk (.sys_clk, .reset_n, .bus_enable,
  .supply_good, .backplane_clock_line_in, .card_data_line_in,
  .backplane_data_line_oe, .backplane_clock_line_oe, .card_data_line_oe,
  .card_clock_line_oe, .connected_flag, .boost_enable, .precharge_enable,
  .state);

// [tb/hsc_top_test.sv]
// Self-checking bench for the connect controller
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  error_cnt++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); \
  end end
module hsc_top_test;
  import hsc_pkg::*;
  localparam int IDLE = 20;
  logic       sys_clk;
  logic       reset_n;
  logic       bus_enable;
  logic       supply_good;
  logic       run_clk;
  logic [3:0] pull;
  wire  [3:0] oe;
  wire  [3:0] line;
  wire  [3:0] out;
  logic       connected_flag;
  logic       boost_enable;
  logic       precharge_enable;
  hsc_state_t state;
  int         error_cnt;
  int         samples_checked;
  int         n;

  hsc_bus_model bus (.run_clk(run_clk), .pull(pull), .oe(oe), .line(line));
  hsc_top #(.IDLE_CYCLES(IDLE)) dut (.sys_clk, .reset_n, .bus_enable,
    .supply_good, .backplane_data_line_in(line[3]),
    .backplane_data_line_out(out[3]), .backplane_data_line_oe(oe[3]),
    .backplane_clock_line_in(line[2]), .backplane_clock_line_out(out[2]),
    .backplane_clock_line_oe(oe[2]), .card_data_line_in(line[1]),
    .card_data_line_out(out[1]), .card_data_line_oe(oe[1]),
    .card_clock_line_in(line[0]), .card_clock_line_out(out[0]),
    .card_clock_line_oe(oe[0]), .connected_flag, .boost_enable,
    .precharge_enable, .state);

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic put(input int i, input logic v);
    @(posedge sys_clk);
    pull[i] <= v;
  endtask
  task automatic en(input logic v);
    @(posedge sys_clk);
    bus_enable <= v;
  endtask
  task automatic wait_flag(output int k);
    k = 0;
    while (connected_flag !== 1'b1 && k < 200) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic t_lockout();
    cyc(30);
    `CHK(state, HSC_LOCKOUT)
    `CHK(precharge_enable, 1'b1)
    `CHK(connected_flag, 1'b0)
    `CHK(oe, 4'h0)
    $display("lockout done");
  endtask
  task automatic t_card_busy();
    put(1, 1'b1);
    @(posedge sys_clk);
    supply_good <= 1'b1;
    cyc(IDLE + 10);
    `CHK(state, HSC_QUALIFY)
    put(1, 1'b0);
    wait_flag(n);
    `CHK(connected_flag, 1'b1)
    `CHK(boost_enable, 1'b1)
    `CHK(precharge_enable, 1'b0)
    $display("card busy done");
  endtask
  task automatic t_wired();
    for (int i = 0; i < 4; i++) begin
      put(i, 1'b1);
      cyc(5);
      `CHK(oe, 4'h1 << (i ^ 2))
      `CHK(out, 4'h0)
      put(i, 1'b0);
      cyc(5);
      `CHK(oe, 4'h0)
    end
    $display("wired and done");
  endtask
  task automatic t_reenable();
    en(1'b0);
    cyc(5);
    `CHK({connected_flag, boost_enable, precharge_enable}, 3'h0)
    `CHK(oe, 4'h0)
    run_clk <= 1'b1;
    en(1'b1);
    cyc(IDLE * 3);
    `CHK(connected_flag, 1'b0)
    run_clk <= 1'b0;
    cyc(10);
    put(3, 1'b1);
    cyc(4);
    put(3, 1'b0);
    wait_flag(n);
    `CHK(n < IDLE, 1'b1)
    en(1'b0);
    cyc(5);
    en(1'b1);
    wait_flag(n);
    `CHK(n >= IDLE && n <= IDLE + 10, 1'b1)
    $display("reenable done");
  endtask
  task automatic t_supply();
    @(posedge sys_clk);
    supply_good <= 1'b0;
    cyc(5);
    `CHK(state, HSC_LOCKOUT)
    `CHK({connected_flag, precharge_enable}, 2'h1)
    `CHK(oe, 4'h0)
    $display("supply drop done");
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
  initial begin
    reset_n = 1'b0;
    bus_enable = 1'b1;
    supply_good = 1'b0;
    run_clk = 1'b0;
    pull = 4'h0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_lockout();
    t_card_busy();
    t_wired();
    t_reenable();
    t_supply();
    test_done();
  end
endmodule
